//--- src/sfcr_pkg.sv
// Shared constants of the serial flash continuous read front end.
// Assumes nothing of its surroundings; used by the design files by scope.
package sfcr_pkg;

    // Opcodes of the two continuous array reads.
    localparam logic [7:0] OPC_READ_LEGACY = 8'he8;
    localparam logic [7:0] OPC_READ_FAST = 8'h0b;

    // Frame field lengths in serial clock bits.
    localparam logic [5:0] OPCODE_BITS = 6'h08;
    localparam logic [5:0] ADDR_BITS = 6'h18;
    localparam logic [5:0] DUMMY_BITS_LEGACY = 6'h20;
    localparam logic [5:0] DUMMY_BITS_FAST = 6'h08;

    // Address layout.
    localparam int PAGE_W = 13;
    localparam int OFFSET_W = 10;
    localparam int LOC_W = PAGE_W + OFFSET_W;
    localparam logic [OFFSET_W-1:0] LAST_OFFSET_528 = 10'h20f;
    localparam logic [OFFSET_W-1:0] LAST_OFFSET_512 = 10'h1ff;
    localparam logic [PAGE_W-1:0] FIRST_PAGE = 13'h0000;
    localparam logic [OFFSET_W-1:0] FIRST_OFFSET = 10'h000;

    // Address bit positions within the 24-bit address field.
    localparam int PAGE_LSB_528 = 10;
    localparam int PAGE_LSB_512 = 9;

    // Pin count of the synchroniser bundle.
    localparam int SYNC_W = 5;
    // Reset levels of the bundle: select high, clock high, data low, pin reset low, 512 strap high.
    localparam logic [SYNC_W-1:0] SYNC_RESET = 5'h19;

    // Reset values.
    localparam logic SO_RESET = 1'b0;
    localparam logic SO_OE_N_RESET = 1'b1;

endpackage

//--- src/sfcr_sync.sv
// Two-flop synchroniser for a bundle of independent level inputs.
// Assumes each bit is a slow level or a clock well below half the system clock.
`timescale 1ns/10ps
`default_nettype none

module sfcr_sync #(
    parameter int WIDTH = 1,
    parameter logic [WIDTH-1:0] RESET_VALUE = '0
) (
    // Clock and reset.
    input wire logic clk_in,
    input wire logic reset_n_in,
    // Levels.
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);

    typedef struct packed {
        logic [WIDTH-1:0] stage2;
        logic [WIDTH-1:0] stage1;
    } sfcr_sync_s;

    sfcr_sync_s r;
    sfcr_sync_s next_r;

    // The first stage feeds only the second stage, so a metastable first
    // flop gets a full clock to settle before any logic sees it.
    always_comb
    begin
        next_r.stage1 = async_in;
        next_r.stage2 = r.stage1;
    end

    always_ff @(posedge clk_in or negedge reset_n_in)
    begin
        if (!reset_n_in)
        begin
            r <= '{stage2: RESET_VALUE, stage1: RESET_VALUE};
        end
        else
        begin
            r <= next_r;
        end
    end

    assign sync_out = r.stage2;

endmodule

`default_nettype wire

//--- src/sfcr_flash_reader.sv
// Serial flash command front end with the two continuous main-array reads.
// Assumes a main-array store on the system clock that presents the byte at
// mem_loc_out on mem_data_in within two system clocks of a change.
`timescale 1ns/10ps
`default_nettype none

// What this block does
// - A frame starts at chip-select fall, then an 8-bit opcode, then the address.
// - With chip select low each serial clock shifts in one opcode or address bit.
// - Opcode, address and data all travel most significant bit first.
// - In 528-byte pages a buffer byte is chosen by a 10-bit buffer address; no buffer command is decoded here.
// - In 528-byte pages a location is a 13-bit page plus 10-bit offset.
// - In 512-byte pages a buffer byte is chosen by a 9-bit buffer address; no buffer command is decoded here.
// - In 512-byte pages address bits 21 to 9 are page, 8 to 0 offset.
// - The serial port works with host clock mode 0 and mode 3.
// - Legacy read is opcode e8, three address bytes, four don't-care bytes.
// - During a continuous read the location counter advances by itself.
// - 528-byte mode takes page from first 13, offset from last 10 of 23 bits.
// - 512-byte mode takes page from first 13, offset from last 9 of 22 bits.
// - After the last legacy don't-care byte each clock shifts data out.
// - At a page end reading continues at the next page start with no gap.
// - After the array's last byte reading wraps to the first page, no gap.
// - Chip select rising ends the read and releases the serial output.
// - Continuous reads fetch from the main array and leave buffers untouched.
// - Fast read is opcode 0b, three address bytes, one dummy byte, both sizes.
// - After the fast read dummy byte each clock shifts data out.
// - The serial output changes only on serial clock falling edges.
// - Reset pin low aborts any operation and holds the sequencer idle.
module sfcr_flash_reader (
    // System clock and reset.
    input wire logic sys_clk_in,
    input wire logic reset_n_in,
    // Serial pins from the host.
    input wire logic cs_n_in,
    input wire logic sck_in,
    input wire logic si_in,
    input wire logic reset_pin_n_in,
    // Page size strap: high selects 512-byte pages.
    input wire logic page_512_in,
    // Serial output pin, enable low while driven.
    output logic so_out,
    output logic so_oe_n_out,
    // Main array read port.
    output logic [sfcr_pkg::LOC_W-1:0] mem_loc_out,
    input wire logic [7:0] mem_data_in,
    // Sequencer status.
    output logic busy_out
);

    typedef enum logic [5:0] {
        ST_IDLE = 6'h01,
        ST_OPCODE = 6'h02,
        ST_ADDR = 6'h04,
        ST_DUMMY = 6'h08,
        ST_DATA = 6'h10,
        ST_IGNORE = 6'h20
    } sfcr_state_e;

    typedef struct packed {
        sfcr_state_e state;
        logic [5:0] bit_cnt;
        logic legacy;
        logic [23:0] in_shift;
        logic [sfcr_pkg::PAGE_W-1:0] page_number;
        logic [sfcr_pkg::OFFSET_W-1:0] page_byte_offset;
        logic [7:0] out_shift;
        logic [2:0] out_cnt;
        logic so;
        logic so_oe_n;
        logic sck_d;
        logic cs_n_d;
        logic busy;
    } sfcr_regs_s;

    localparam sfcr_regs_s REGS_RESET = '{
        state: ST_IDLE,
        bit_cnt: 6'h00,
        legacy: 1'b0,
        in_shift: 24'h000000,
        page_number: sfcr_pkg::FIRST_PAGE,
        page_byte_offset: sfcr_pkg::FIRST_OFFSET,
        out_shift: 8'h00,
        out_cnt: 3'h0,
        so: sfcr_pkg::SO_RESET,
        so_oe_n: sfcr_pkg::SO_OE_N_RESET,
        sck_d: 1'b1,
        cs_n_d: 1'b1,
        busy: 1'b0
    };

    // Next location of a continuous read. The page counter is exactly 13 bits,
    // so stepping past the last page wraps to the first by itself.
    function automatic logic [sfcr_pkg::LOC_W-1:0] next_loc(
        input logic [sfcr_pkg::PAGE_W-1:0] page,
        input logic [sfcr_pkg::OFFSET_W-1:0] offset,
        input logic p512
    );
        logic [sfcr_pkg::OFFSET_W-1:0] last;
        last = p512 ? sfcr_pkg::LAST_OFFSET_512 : sfcr_pkg::LAST_OFFSET_528;
        if (offset == last)
        begin
            next_loc = {page + 13'h0001, sfcr_pkg::FIRST_OFFSET};
        end
        else
        begin
            next_loc = {page, offset + 10'h001};
        end
    endfunction

    // Split of a received 24-bit address into page and offset. A buffer byte
    // address has the offset's width; no buffer command is decoded here.
    function automatic logic [sfcr_pkg::LOC_W-1:0] split_addr(
        input logic [23:0] addr,
        input logic p512
    );
        if (p512)
        begin
            split_addr = {addr[sfcr_pkg::PAGE_LSB_512 +: sfcr_pkg::PAGE_W],
                          1'b0, addr[sfcr_pkg::PAGE_LSB_512-1:0]};
        end
        else
        begin
            split_addr = {addr[sfcr_pkg::PAGE_LSB_528 +: sfcr_pkg::PAGE_W],
                          addr[sfcr_pkg::PAGE_LSB_528-1:0]};
        end
    endfunction

    logic [sfcr_pkg::SYNC_W-1:0] pins_sync;
    logic cs_n_s;
    logic sck_s;
    logic si_s;
    logic reset_pin_n_s;
    logic page_512_s;
    logic sck_rise;
    logic sck_fall;
    logic [5:0] bit_next;
    logic [23:0] shift_next;
    logic [5:0] dummy_last;
    sfcr_regs_s r;
    sfcr_regs_s next_r;

    // Every pin is asynchronous to the system clock, the serial clock included.
    sfcr_sync #(
        .WIDTH(sfcr_pkg::SYNC_W),
        .RESET_VALUE(sfcr_pkg::SYNC_RESET)
    ) u_pin_sync (
        .clk_in(sys_clk_in),
        .reset_n_in(reset_n_in),
        .async_in({cs_n_in, sck_in, si_in, reset_pin_n_in, page_512_in}),
        .sync_out(pins_sync)
    );

    assign {cs_n_s, sck_s, si_s, reset_pin_n_s, page_512_s} = pins_sync;
    assign sck_rise = sck_s & ~r.sck_d;
    assign sck_fall = ~sck_s & r.sck_d;
    assign bit_next = r.bit_cnt + 6'h01;
    assign shift_next = {r.in_shift[22:0], si_s};
    assign dummy_last = (r.legacy ? sfcr_pkg::DUMMY_BITS_LEGACY : sfcr_pkg::DUMMY_BITS_FAST) - 6'h01;

    always_comb
    begin
        next_r = r;
        next_r.sck_d = sck_s;
        next_r.cs_n_d = cs_n_s;
        if (!reset_pin_n_s)
        begin
            next_r.state = ST_IDLE;
            next_r.so_oe_n = sfcr_pkg::SO_OE_N_RESET;
            next_r.bit_cnt = 6'h00;
            next_r.busy = 1'b0;
        end
        else if (cs_n_s)
        begin
            next_r.state = ST_IDLE;
            next_r.so_oe_n = sfcr_pkg::SO_OE_N_RESET;
            next_r.bit_cnt = 6'h00;
            next_r.busy = 1'b0;
        end
        else
        begin
            case (r.state)
                ST_IDLE:
                begin
                    // Only a fresh fall starts a frame; a select held low
                    // through a pin reset is not a command.
                    if (r.cs_n_d)
                    begin
                        next_r.state = ST_OPCODE;
                        next_r.bit_cnt = 6'h00;
                        next_r.busy = 1'b1;
                    end
                end
                ST_OPCODE:
                begin
                    // Only rising edges count, so the leading fall of mode 3
                    // is ignored and modes 0 and 3 frame alike.
                    if (sck_rise)
                    begin
                        next_r.in_shift = shift_next;
                        next_r.bit_cnt = bit_next;
                        if (r.bit_cnt == sfcr_pkg::OPCODE_BITS - 6'h01)
                        begin
                            next_r.bit_cnt = 6'h00;
                            if (shift_next[7:0] == sfcr_pkg::OPC_READ_LEGACY)
                            begin
                                next_r.state = ST_ADDR;
                                next_r.legacy = 1'b1;
                            end
                            else if (shift_next[7:0] == sfcr_pkg::OPC_READ_FAST)
                            begin
                                next_r.state = ST_ADDR;
                                next_r.legacy = 1'b0;
                            end
                            else
                            begin
                                next_r.state = ST_IGNORE;
                            end
                        end
                    end
                end
                ST_ADDR:
                begin
                    if (sck_rise)
                    begin
                        next_r.in_shift = shift_next;
                        next_r.bit_cnt = bit_next;
                        if (r.bit_cnt == sfcr_pkg::ADDR_BITS - 6'h01)
                        begin
                            next_r.bit_cnt = 6'h00;
                            next_r.state = ST_DUMMY;
                            {next_r.page_number, next_r.page_byte_offset} =
                                split_addr(shift_next, page_512_s);
                        end
                    end
                end
                ST_DUMMY:
                begin
                    if (sck_rise)
                    begin
                        next_r.bit_cnt = bit_next;
                        if (r.bit_cnt == dummy_last)
                        begin
                            next_r.state = ST_DATA;
                            next_r.out_cnt = 3'h0;
                        end
                    end
                end
                ST_DATA:
                begin
                    if (sck_fall)
                    begin
                        next_r.so_oe_n = 1'b0;
                        next_r.out_cnt = r.out_cnt + 3'h1;
                        if (r.out_cnt == 3'h0)
                        begin
                            // Straight from the main array; no buffer is touched.
                            next_r.so = mem_data_in[7];
                            next_r.out_shift = {mem_data_in[6:0], 1'b0};
                            {next_r.page_number, next_r.page_byte_offset} =
                                next_loc(r.page_number, r.page_byte_offset, page_512_s);
                        end
                        else
                        begin
                            next_r.so = r.out_shift[7];
                            next_r.out_shift = {r.out_shift[6:0], 1'b0};
                        end
                    end
                end
                ST_IGNORE:
                begin
                    next_r.state = ST_IGNORE;
                end
                default:
                begin
                    next_r.state = ST_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge sys_clk_in or negedge reset_n_in)
    begin
        if (!reset_n_in)
        begin
            r <= REGS_RESET;
        end
        else
        begin
            r <= next_r;
        end
    end

    // The pin path costs about three system clocks, so the serial clock must
    // stay well below an eighth of the system clock; full-rate reads are out
    // of reach of this sampled design.
    assign so_out = r.so;
    assign so_oe_n_out = r.so_oe_n;
    assign mem_loc_out = {r.page_number, r.page_byte_offset};
    assign busy_out = r.busy;

endmodule

`default_nettype wire

//--- test/sfcr_flash_reader_sva.sv
// Port-level checker for the serial flash continuous read front end.
// Assumes it is bound to sfcr_flash_reader and sees only its ports.
`timescale 1ns/10ps
`default_nettype none

module sfcr_flash_reader_sva (
    // Clock and reset.
    input wire logic sys_clk_in,
    input wire logic reset_n_in,
    // Pins and outputs watched.
    input wire logic cs_n_in,
    input wire logic sck_in,
    input wire logic reset_pin_n_in,
    input wire logic page_512_in,
    input wire logic so_out,
    input wire logic so_oe_n_out,
    input wire logic [sfcr_pkg::LOC_W-1:0] mem_loc_out,
    input wire logic busy_out
);
    default clocking cb @(posedge sys_clk_in);
    endclocking
    default disable iff (!reset_n_in);

    sequence s_cs_idle;
        cs_n_in [*8];
    endsequence
    sequence s_streaming;
        !so_oe_n_out && $past(!so_oe_n_out) && $changed(mem_loc_out);
    endsequence

    a_cs_release: assert property (s_cs_idle |-> so_oe_n_out)
        else $error("serial output still driven after chip select rose");
    a_idle_busy: assert property (s_cs_idle |-> !busy_out)
        else $error("busy without a frame");
    a_busy_start: assert property ($fell(cs_n_in) && reset_pin_n_in |-> ##[1:5] busy_out)
        else $error("frame start not seen");
    // Page wrap is checked against the strap, so a 512-byte run may not step to offset 512.
    a_loc_step: assert property (s_streaming |->
        (($past(mem_loc_out[9:0]) == (page_512_in ? sfcr_pkg::LAST_OFFSET_512 : sfcr_pkg::LAST_OFFSET_528))
        ? (mem_loc_out == {$past(mem_loc_out[22:10]) + 13'h0001, 10'h000})
        : (mem_loc_out == $past(mem_loc_out) + 23'h000001)))
        else $error("location counter stepped wrongly");
    a_so_on_fall: assert property ($changed(so_out) |-> !sck_in)
        else $error("serial output changed while serial clock high");
    a_oe_on_fall: assert property ($fell(so_oe_n_out) |-> !sck_in && !cs_n_in)
        else $error("output enabled outside a data phase fall");
    a_pin_reset: assert property (!reset_pin_n_in [*6] |-> so_oe_n_out && !busy_out)
        else $error("reset pin did not idle the sequencer");
    a_oe_needs_cs: assert property (!so_oe_n_out |-> !$past(cs_n_in, 5))
        else $error("output driven without chip select");
endmodule

`default_nettype wire

//--- test/sfcr_host_model.sv
// Behavioural host acting as serial bus master of the flash.
// Assumes its caller starts a frame just after a system clock edge.
`timescale 1ns/10ps
`default_nettype none

module sfcr_host_model (
    // Serial pins towards the flash.
    output logic cs_n_out,
    output logic sck_out,
    output logic si_out,
    // Serial output back from the flash.
    input wire logic so_in,
    input wire logic so_oe_n_in
);
    logic [7:0] got [$];
    logic drove;

    initial
    begin
        cs_n_out = 1'b1;
        sck_out = 1'b0;
        si_out = 1'b0;
        drove = 1'b0;
    end

    // Input changes at the fall so the flash sees it settled at the rise.
    task automatic shift_bit(input logic b);
        sck_out = 1'b0;
        si_out = b;
        #100;
        sck_out = 1'b1;
        #100;
    endtask

    // Output is read late in the high phase, well after the flash updates it.
    task automatic frame(input logic [7:0] opc, input logic [23:0] addr, input int nd, input int n,
        input logic m3);
        logic [31:0] cmd;
        logic [7:0] b;
        cmd = {opc, addr};
        got.delete();
        drove = 1'b0;
        sck_out = m3;
        #100;
        cs_n_out = 1'b0;
        #100;
        for (int i = 31; i >= 0; i--)
            shift_bit(cmd[i]);
        for (int i = 0; i < nd; i++)
            shift_bit(~si_out);
        for (int k = 0; k < n; k++)
        begin
            for (int i = 7; i >= 0; i--)
            begin
                shift_bit(~si_out);
                b[i] = (so_oe_n_in === 1'b0) ? so_in : 1'bx;
                drove = drove | (so_oe_n_in === 1'b0);
            end
            got.push_back(b);
        end
        if (!m3)
            sck_out = 1'b0;
        #100;
        cs_n_out = 1'b1;
        #200;
    endtask
endmodule

`default_nettype wire

//--- test/test_sfcr_flash_reader.sv
// Self-checking bench for the continuous read front end.
// Assumes the host model and a combinational main-array model built here.
`timescale 1ns/10ps
`default_nettype none

module test_sfcr_flash_reader;
    logic clk, rst_n, rpin_n, p512, cs_n, sck, si, so, so_oe_n, busy;
    logic [sfcr_pkg::LOC_W-1:0] loc;
    logic [7:0] mem_data;
    int mismatches, checks_done;

    function automatic logic [7:0] mem_byte(input logic [22:0] l);
        return l[7:0] ^ {l[9:8], l[15:10]} ^ {1'b0, l[22:16]};
    endfunction
    assign mem_data = mem_byte(loc);

    sfcr_flash_reader DUT (.sys_clk_in(clk), .reset_n_in(rst_n), .cs_n_in(cs_n), .sck_in(sck),
        .si_in(si), .reset_pin_n_in(rpin_n), .page_512_in(p512), .so_out(so), .so_oe_n_out(so_oe_n),
        .mem_loc_out(loc), .mem_data_in(mem_data), .busy_out(busy));
    sfcr_host_model host (.cs_n_out(cs_n), .sck_out(sck), .si_out(si), .so_in(so), .so_oe_n_in(so_oe_n));

    task automatic check(input logic ok, input string what);
        checks_done++;
        if (ok !== 1'b1)
        begin
            mismatches++;
            $display("unexpected at %0t: %s", $time, what);
        end
    endtask

    task automatic results();
        $display("checks %0d mismatches %0d", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    task automatic run(input logic [7:0] opc, input logic p, input logic m3, input logic [12:0] pg,
        input logic [9:0] of, input int nd, input int n, input string name);
        logic [23:0] a;
        a = p ? {2'b00, pg, of[8:0]} : {1'b0, pg, of};
        p512 = p;
        host.frame(opc, a, nd, n, m3);
        check(host.drove === 1'b1, "no data driven");
        for (int k = 0; k < n; k++)
        begin
            check(host.got[k] === mem_byte({pg, of}), "wrong data byte");
            if (of == (p ? sfcr_pkg::LAST_OFFSET_512 : sfcr_pkg::LAST_OFFSET_528))
            begin
                of = 10'h000;
                pg = pg + 13'h0001;
            end
            else
                of = of + 10'h001;
        end
        check(so_oe_n === 1'b1 && busy === 1'b0, "output held after chip select rose");
        $display("%s done", name);
    endtask

    task automatic t_fast_528();
        run(sfcr_pkg::OPC_READ_FAST, 1'b0, 1'b0, 13'h0005, 10'h20e, 8, 3, "fast 528");
    endtask

    task automatic t_fast_512_m3();
        run(sfcr_pkg::OPC_READ_FAST, 1'b1, 1'b1, 13'h1234, 10'h1fe, 8, 3, "fast 512 mode 3");
    endtask

    task automatic t_legacy_512_wrap();
        run(sfcr_pkg::OPC_READ_LEGACY, 1'b1, 1'b0, 13'h1fff, 10'h1ff, 32, 2, "legacy 512 wrap");
    endtask

    task automatic t_legacy_528_wrap_m3();
        run(sfcr_pkg::OPC_READ_LEGACY, 1'b0, 1'b1, 13'h1fff, 10'h20f, 32, 2, "legacy 528 wrap");
    endtask

    task automatic t_bad_opcode();
        host.frame(8'h03, 24'h000010, 0, 2, 1'b0);
        check(host.drove === 1'b0, "unknown opcode drove the output");
        $display("bad opcode done");
    endtask

    // The pin reset lands mid-stream while chip select stays low, so no restart may follow.
    task automatic t_reset_pin();
        fork
            host.frame(sfcr_pkg::OPC_READ_FAST, 24'h001020, 8, 3, 1'b0);
            begin
                #(45 * 200);
                rpin_n = 1'b0;
                repeat (8) @(posedge clk);
                check(so_oe_n === 1'b1 && busy === 1'b0, "reset pin ignored");
                #1 rpin_n = 1'b1;
                repeat (8) @(posedge clk);
                check(so_oe_n === 1'b1 && busy === 1'b0, "restart without chip select fall");
            end
        join
        $display("reset pin done");
    endtask

    initial
    begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    initial
    begin
        #300000;
        mismatches++;
        results();
    end

    initial
    begin
        rst_n = 1'b0;
        rpin_n = 1'b1;
        p512 = 1'b0;
        mismatches = 0;
        checks_done = 0;
        repeat (20) @(posedge clk);
        #1 rst_n = 1'b1;
        repeat (4) @(posedge clk);
        #1;
        check(so_oe_n === 1'b1 && busy === 1'b0 && loc === '0, "outputs not idle after reset");
        t_fast_528();
        t_fast_512_m3();
        t_legacy_512_wrap();
        t_legacy_528_wrap_m3();
        t_bad_opcode();
        t_reset_pin();
        results();
    end
endmodule

bind sfcr_flash_reader sfcr_flash_reader_sva u_sva (.sys_clk_in(sys_clk_in), .reset_n_in(reset_n_in),
    .cs_n_in(cs_n_in), .sck_in(sck_in), .reset_pin_n_in(reset_pin_n_in), .page_512_in(page_512_in),
    .so_out(so_out), .so_oe_n_out(so_oe_n_out), .mem_loc_out(mem_loc_out), .busy_out(busy_out));

`default_nettype wire
